// *** logic/ttcp_defs.svh ***
// Register offsets, field positions, interrupt bits, reset values and prescaler width of the timer block
`ifndef TTCP_DEFS_SVH
`define TTCP_DEFS_SVH

// ***********************************************************
// Register byte addresses
// ***********************************************************
`define TTCP_OFF_BYTE_CTRL     8'h00
`define TTCP_OFF_BYTE_CMP      8'h04
`define TTCP_OFF_BYTE_CNT      8'h08
`define TTCP_OFF_BYTE_CAP      8'h0c
`define TTCP_OFF_WA_CTRL       8'h10
`define TTCP_OFF_WA_DATA_A     8'h14
`define TTCP_OFF_WA_DATA_B     8'h18
`define TTCP_OFF_WA_CNT        8'h1c
`define TTCP_OFF_WB_CTRL       8'h20
`define TTCP_OFF_WB_DATA_A     8'h24
`define TTCP_OFF_WB_DATA_B     8'h28
`define TTCP_OFF_WB_CNT        8'h2c
`define TTCP_OFF_IRQ_STAT      8'h30
`define TTCP_OFF_IRQ_MASK      8'h34

// ***********************************************************
// Control fields, common to all three timers except the pin function, which only the two 16-bit timers use
// ***********************************************************
`define TTCP_CTRL_EN           0
`define TTCP_CTRL_MODE_LO      1
`define TTCP_CTRL_MODE_HI      2
`define TTCP_CTRL_CLK_LO       3
`define TTCP_CTRL_CLK_HI       5
`define TTCP_CTRL_FN_LO        6
`define TTCP_CTRL_FN_HI        7
`define TTCP_CLK_SEL_ALT       3'h7
`define TTCP_FN_OUTPUT         2'h3
`define TTCP_FN_CAPTURE        2'h0

// ***********************************************************
// Interrupt status bits
// ***********************************************************
`define TTCP_IRQ_BYTE_OVF      0
`define TTCP_IRQ_BYTE_MATCH    1
`define TTCP_IRQ_WA_MATCH      2
`define TTCP_IRQ_WB_MATCH      3

// ***********************************************************
// Reset values and prescaler width
// ***********************************************************
`define TTCP_RST_CTRL          8'h00
`define TTCP_RST_BYTE_DATA     8'h00
`define TTCP_RST_WIDE_DATA     16'h0000
`define TTCP_RST_IRQ           4'h0
`define TTCP_PRESCALE_W        11

`endif

// *** logic/ttcp_pkg.sv ***
// Types and clock-select decoding shared by the timer block
package ttcp_pkg;

  typedef enum logic [1:0] {
    TTCP_WMODE_TIMER   = 2'b00,
    TTCP_WMODE_CAPTURE = 2'b01,
    TTCP_WMODE_ONESHOT = 2'b10,
    TTCP_WMODE_REPEAT  = 2'b11
  } ttcp_wide_mode_t;

  typedef struct packed {
    logic [15:0] cnt;
    logic [15:0] data_b;
    logic        tgl;
    logic        cmp_pin;
    logic        pwm_pin;
    logic        stopped;
    logic        a_match;
  } ttcp_wide_state_t;

  typedef struct packed {
    logic [10:0] pre;
    logic [7:0]  b_ctrl;
    logic [7:0]  b_cmp;
    logic [7:0]  b_cnt;
    logic [7:0]  b_cap;
    logic        b_tgl;
    logic        b_pwm;
    logic [7:0]  wa_ctrl;
    logic [15:0] wa_data_a;
    logic [7:0]  wb_ctrl;
    logic [15:0] wb_data_a;
    logic [3:0]  irq_stat;
    logic [3:0]  irq_mask;
    logic        irq;
    logic [31:0] prdata;
    logic        pslverr;
    logic [4:0]  sync1;
    logic [4:0]  sync2;
    logic [4:0]  sync3;
  } ttcp_top_state_t;

  // Tick when the low lg prescaler bits are all ones; lg of zero ticks every cycle
  function automatic logic ttcp_div_tick(input logic [10:0] pre, input logic [3:0] lg);
    logic [11:0] mask;
    mask = (12'h001 << lg) - 12'h001;
    return (pre & mask[10:0]) == mask[10:0];
  endfunction

  function automatic logic [3:0] ttcp_byte_lg(input logic [2:0] sel);
    case (sel)
      3'h0:    return 4'h1;
      3'h1:    return 4'h2;
      3'h2:    return 4'h3;
      3'h3:    return 4'h5;
      3'h4:    return 4'h7;
      3'h5:    return 4'h9;
      default: return 4'hb;
    endcase
  endfunction

  function automatic logic [3:0] ttcp_wa_lg(input logic [2:0] sel);
    case (sel)
      3'h0:    return 4'h0;
      3'h1:    return 4'h1;
      3'h2:    return 4'h2;
      3'h3:    return 4'h3;
      3'h4:    return 4'h6;
      3'h5:    return 4'h9;
      default: return 4'hb;
    endcase
  endfunction

  function automatic logic [3:0] ttcp_wb_lg(input logic [2:0] sel);
    case (sel)
      3'h0:    return 4'h0;
      3'h1:    return 4'h1;
      3'h2:    return 4'h2;
      3'h3:    return 4'h3;
      3'h4:    return 4'h5;
      3'h5:    return 4'h7;
      default: return 4'h9;
    endcase
  endfunction

endpackage

// *** logic/ttcp_wide_if.sv ***
// Connection between the register block and one 16-bit timer
`timescale 1ns/1ps
interface ttcp_wide_if;
  logic        enable;
  logic [1:0]  mode;
  logic [1:0]  pin_func;
  logic [15:0] data_a;
  logic        tick;
  logic        capture_evt;
  logic        b_wr;
  logic [15:0] b_wdata;
  logic [15:0] count;
  logic [15:0] data_b;
  logic        a_match;
  logic        cmp_out;
  logic        pwm_out;

  modport ctrl (output enable, mode, pin_func, data_a, tick, capture_evt, b_wr, b_wdata,
                input count, data_b, a_match, cmp_out, pwm_out);
  modport tmr  (input enable, mode, pin_func, data_a, tick, capture_evt, b_wr, b_wdata,
                output count, data_b, a_match, cmp_out, pwm_out);
endinterface

// *** logic/ttcp_wide_timer.sv ***
// One 16-bit timer: timer/counter, capture, one-shot and repeat pulse modes
`timescale 1ns/1ps
`include "ttcp_defs.svh"
module ttcp_wide_timer
  import ttcp_pkg::*;
#(
  parameter int WIDTH = 16
)(
  input  wire logic pclk,
  input  wire logic presetn,
  ttcp_wide_if.tmr  bus
);

  // Checked at elaboration: the state struct holds a 16-bit count
  if (WIDTH != 16)
  begin : g_width_check
    $error("ttcp_wide_timer serves a 16-bit counter only");
  end

  ttcp_wide_state_t st;
  ttcp_wide_state_t next_st;
  ttcp_wide_mode_t  mode;
  logic             ppg;

  assign mode = ttcp_wide_mode_t'(bus.mode);
  assign ppg  = (mode == TTCP_WMODE_ONESHOT) || (mode == TTCP_WMODE_REPEAT);

  always_comb
  begin
    next_st         = st;
    next_st.a_match = 1'b0;
    if (!bus.enable)
    begin
      next_st.cnt     = 16'h0000;
      next_st.tgl     = 1'b0;
      next_st.stopped = 1'b0;
    end
    else if (bus.tick && !st.stopped)
    begin
      case (mode)
        TTCP_WMODE_TIMER:
        begin
          if (st.cnt == bus.data_a)
          begin
            next_st.cnt     = 16'h0000;
            next_st.tgl     = ~st.tgl;
            next_st.a_match = 1'b1;
          end
          else
            next_st.cnt = st.cnt + 16'h0001;
        end
        TTCP_WMODE_CAPTURE:
        begin
          // Free running so that captures measure absolute time
          next_st.cnt     = st.cnt + 16'h0001;
          next_st.a_match = (st.cnt == bus.data_a);
        end
        default:
        begin
          if (st.cnt == bus.data_a)
          begin
            next_st.cnt     = 16'h0000;
            next_st.a_match = 1'b1;
            next_st.stopped = (mode == TTCP_WMODE_ONESHOT);
          end
          else
            next_st.cnt = st.cnt + 16'h0001;
        end
      endcase
    end
    // Hardware capture wins over a software write in the same cycle
    if (bus.enable && mode == TTCP_WMODE_CAPTURE && bus.pin_func == `TTCP_FN_CAPTURE
        && bus.capture_evt)
      next_st.data_b = st.cnt;
    else if (bus.b_wr)
      next_st.data_b = bus.b_wdata;
    next_st.cmp_pin = bus.enable && mode == TTCP_WMODE_TIMER
                      && bus.pin_func == `TTCP_FN_OUTPUT && next_st.tgl;
    // High from period start until duty match, low after a one-shot ends
    next_st.pwm_pin = bus.enable && ppg && bus.pin_func == `TTCP_FN_OUTPUT
                      && !next_st.stopped && (next_st.cnt < next_st.data_b);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st <= '0;
    else
      st <= next_st;
  end

  assign bus.count   = st.cnt;
  assign bus.data_b  = st.data_b;
  assign bus.a_match = st.a_match;
  assign bus.cmp_out = st.cmp_pin;
  assign bus.pwm_out = st.pwm_pin;

endmodule // ttcp_wide_timer

// *** logic/ttcp_top.sv ***
// Three-timer block with APB registers, pin synchronisers and interrupt flags
//
// Function
// - Byte timer mode 00 counts, 01 makes PWM, 1x captures.
// - Byte timer clock is fx/2..fx/2048 or its external clock pin.
// - Byte timer capture copies count on line-one event.
// - Byte timer counter mode toggles its pin on compare equality.
// - Byte timer PWM mode drives its PWM pin.
// - Timer A modes 00,01,10,11; pin function 11 outputs, 00 capture.
// - Timer A clock is fx/1..fx/2048 or its external clock pin.
// - Timer A capture loads count into data B on line-two event.
// - Timer A counter mode toggles its pin when count equals data A.
// - Timer A pulse modes drive its PWM pin.
// - Timer B modes 00,01,10,11; pin function 11 outputs, 00 capture.
// - Timer B clock is fx/1..fx/512 or timer A match.
// - Timer B capture loads count into data B on line-three event.
// - Timer B counter mode toggles its pin when count equals data A.
// - Timer B pulse modes drive its PWM pin.
// - Interrupt flags set on event, hold until accepted, clear when serviced.
`timescale 1ns/1ps
`include "ttcp_defs.svh"
module ttcp_top
  import ttcp_pkg::*;
#(
  parameter int PRESCALE_W = `TTCP_PRESCALE_W
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        byte_timer_ext_clk,
  input  wire logic        wide_a_ext_clk,
  input  wire logic        ext_irq_line_one,
  input  wire logic        ext_irq_line_two,
  input  wire logic        ext_irq_line_three,
  input  wire logic [3:0]  irq_ack,
  output logic             byte_timer_toggle_out,
  output logic             byte_timer_pwm_out,
  output logic             wide_a_compare_out,
  output logic             wide_a_pwm_out,
  output logic             wide_b_toggle_out,
  output logic             wide_b_pwm_out,
  output logic             irq
);

  // Checked at elaboration: a narrower prescaler cannot reach the slowest tap
  if (PRESCALE_W != `TTCP_PRESCALE_W)
  begin : g_pre_check
    $error("ttcp_top needs an 11-bit prescaler for the fx/2048 tap");
  end

  // ***********************************************************
  // Signals
  // ***********************************************************
  ttcp_top_state_t st;
  ttcp_top_state_t next_st;
  logic [4:0]      pin_raw;
  logic [4:0]      pin_rise;
  logic            apb_wr;
  logic            apb_setup;
  logic            byte_tick;
  logic            byte_en;
  logic [1:0]      byte_mode;
  logic [2:0]      byte_clk;
  logic [2:0]      wa_clk;
  logic [2:0]      wb_clk;
  logic [3:0]      irq_set;
  logic [3:0]      irq_w1c;

  ttcp_wide_if wa_if ();
  ttcp_wide_if wb_if ();

  // Bit order of the synchronised pins
  localparam int PIN_BYTE_CLK = 0;
  localparam int PIN_WA_CLK   = 1;
  localparam int PIN_LINE_1   = 2;
  localparam int PIN_LINE_2   = 3;
  localparam int PIN_LINE_3   = 4;

  assign pin_raw = {ext_irq_line_three, ext_irq_line_two, ext_irq_line_one,
                    wide_a_ext_clk, byte_timer_ext_clk};

  // ***********************************************************
  // Pin edge detection
  // ***********************************************************
  // Rising edges only; the second and third stages are compared, never the first
  genvar gi;
  generate
    for (gi = 0; gi < 5; gi++)
    begin : g_edge
      assign pin_rise[gi] = st.sync2[gi] & ~st.sync3[gi];
    end
  endgenerate

  // ***********************************************************
  // Control field decode
  // ***********************************************************
  assign byte_en   = st.b_ctrl[`TTCP_CTRL_EN];
  assign byte_mode = st.b_ctrl[`TTCP_CTRL_MODE_HI:`TTCP_CTRL_MODE_LO];
  assign byte_clk  = st.b_ctrl[`TTCP_CTRL_CLK_HI:`TTCP_CTRL_CLK_LO];
  assign wa_clk    = st.wa_ctrl[`TTCP_CTRL_CLK_HI:`TTCP_CTRL_CLK_LO];
  assign wb_clk    = st.wb_ctrl[`TTCP_CTRL_CLK_HI:`TTCP_CTRL_CLK_LO];

  // ***********************************************************
  // Count clock selection
  // ***********************************************************
  // External clocks count on their synchronised rising edge, so they must stay
  // below a quarter of pclk to be seen reliably
  assign byte_tick = (byte_clk == `TTCP_CLK_SEL_ALT) ? pin_rise[PIN_BYTE_CLK]
                   : ttcp_div_tick(st.pre, ttcp_byte_lg(byte_clk));

  assign wa_if.tick = (wa_clk == `TTCP_CLK_SEL_ALT) ? pin_rise[PIN_WA_CLK]
                    : ttcp_div_tick(st.pre, ttcp_wa_lg(wa_clk));

  // The match output is a one-cycle pulse, so each match gives one count
  assign wb_if.tick = (wb_clk == `TTCP_CLK_SEL_ALT) ? wa_if.a_match
                    : ttcp_div_tick(st.pre, ttcp_wb_lg(wb_clk));

  // ***********************************************************
  // Wide timer connections
  // ***********************************************************
  assign apb_setup = psel & ~penable;
  assign apb_wr    = psel & penable & pwrite;

  assign wa_if.enable      = st.wa_ctrl[`TTCP_CTRL_EN];
  assign wa_if.mode        = st.wa_ctrl[`TTCP_CTRL_MODE_HI:`TTCP_CTRL_MODE_LO];
  assign wa_if.pin_func    = st.wa_ctrl[`TTCP_CTRL_FN_HI:`TTCP_CTRL_FN_LO];
  assign wa_if.data_a      = st.wa_data_a;
  assign wa_if.capture_evt = pin_rise[PIN_LINE_2];
  assign wa_if.b_wr        = apb_wr && paddr == `TTCP_OFF_WA_DATA_B;
  assign wa_if.b_wdata     = pwdata[15:0];

  assign wb_if.enable      = st.wb_ctrl[`TTCP_CTRL_EN];
  assign wb_if.mode        = st.wb_ctrl[`TTCP_CTRL_MODE_HI:`TTCP_CTRL_MODE_LO];
  assign wb_if.pin_func    = st.wb_ctrl[`TTCP_CTRL_FN_HI:`TTCP_CTRL_FN_LO];
  assign wb_if.data_a      = st.wb_data_a;
  assign wb_if.capture_evt = pin_rise[PIN_LINE_3];
  assign wb_if.b_wr        = apb_wr && paddr == `TTCP_OFF_WB_DATA_B;
  assign wb_if.b_wdata     = pwdata[15:0];

  ttcp_wide_timer #(
    .WIDTH   (16)
  ) u_wide_a (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (wa_if)
  );

  ttcp_wide_timer #(
    .WIDTH   (16)
  ) u_wide_b (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (wb_if)
  );

  // ***********************************************************
  // Register decode
  // ***********************************************************
  function automatic logic ttcp_mapped(input logic [7:0] addr);
    case (addr)
      `TTCP_OFF_BYTE_CTRL, `TTCP_OFF_BYTE_CMP, `TTCP_OFF_BYTE_CNT, `TTCP_OFF_BYTE_CAP,
      `TTCP_OFF_WA_CTRL, `TTCP_OFF_WA_DATA_A, `TTCP_OFF_WA_DATA_B, `TTCP_OFF_WA_CNT,
      `TTCP_OFF_WB_CTRL, `TTCP_OFF_WB_DATA_A, `TTCP_OFF_WB_DATA_B, `TTCP_OFF_WB_CNT,
      `TTCP_OFF_IRQ_STAT, `TTCP_OFF_IRQ_MASK:
        return 1'b1;
      default:
        return 1'b0;
    endcase
  endfunction

  function automatic logic [31:0] ttcp_read(input logic [7:0] addr,
                                            input ttcp_top_state_t s,
                                            input logic [15:0] wa_b,
                                            input logic [15:0] wa_c,
                                            input logic [15:0] wb_b,
                                            input logic [15:0] wb_c);
    case (addr)
      `TTCP_OFF_BYTE_CTRL: return {24'h000000, s.b_ctrl};
      `TTCP_OFF_BYTE_CMP:  return {24'h000000, s.b_cmp};
      `TTCP_OFF_BYTE_CNT:  return {24'h000000, s.b_cnt};
      `TTCP_OFF_BYTE_CAP:  return {24'h000000, s.b_cap};
      `TTCP_OFF_WA_CTRL:   return {24'h000000, s.wa_ctrl};
      `TTCP_OFF_WA_DATA_A: return {16'h0000, s.wa_data_a};
      `TTCP_OFF_WA_DATA_B: return {16'h0000, wa_b};
      `TTCP_OFF_WA_CNT:    return {16'h0000, wa_c};
      `TTCP_OFF_WB_CTRL:   return {24'h000000, s.wb_ctrl};
      `TTCP_OFF_WB_DATA_A: return {16'h0000, s.wb_data_a};
      `TTCP_OFF_WB_DATA_B: return {16'h0000, wb_b};
      `TTCP_OFF_WB_CNT:    return {16'h0000, wb_c};
      `TTCP_OFF_IRQ_STAT:  return {28'h0000000, s.irq_stat};
      `TTCP_OFF_IRQ_MASK:  return {28'h0000000, s.irq_mask};
      default:             return 32'h00000000;
    endcase
  endfunction

  assign irq_w1c = (apb_wr && paddr == `TTCP_OFF_IRQ_STAT) ? pwdata[3:0] : 4'h0;

  // ***********************************************************
  // Next state
  // ***********************************************************
  always_comb
  begin
    next_st       = st;
    irq_set       = 4'h0;
    next_st.pre   = st.pre + 11'h001;
    next_st.sync1 = pin_raw;
    next_st.sync2 = st.sync1;
    next_st.sync3 = st.sync2;

    // Byte timer
    if (!byte_en)
    begin
      next_st.b_cnt = 8'h00;
      next_st.b_tgl = 1'b0;
    end
    else if (byte_tick)
    begin
      case (byte_mode)
        2'b00:
        begin
          if (st.b_cnt == st.b_cmp)
          begin
            next_st.b_cnt = 8'h00;
            next_st.b_tgl = ~st.b_tgl;
            irq_set[`TTCP_IRQ_BYTE_MATCH] = 1'b1;
          end
          else
            next_st.b_cnt = st.b_cnt + 8'h01;
        end
        default:
        begin
          next_st.b_cnt = st.b_cnt + 8'h01;
          irq_set[`TTCP_IRQ_BYTE_OVF] = (st.b_cnt == 8'hff);
        end
      endcase
    end
    if (byte_en && byte_mode[1] && pin_rise[PIN_LINE_1])
      next_st.b_cap = st.b_cnt;
    // Duty is the compare value in counts out of 256
    next_st.b_pwm = byte_en && byte_mode == 2'b01 && (next_st.b_cnt < st.b_cmp);

    irq_set[`TTCP_IRQ_WA_MATCH] = wa_if.a_match;
    irq_set[`TTCP_IRQ_WB_MATCH] = wb_if.a_match;

    // Register writes take effect on the access edge
    if (apb_wr)
    begin
      case (paddr)
        `TTCP_OFF_BYTE_CTRL: next_st.b_ctrl    = pwdata[7:0];
        `TTCP_OFF_BYTE_CMP:  next_st.b_cmp     = pwdata[7:0];
        `TTCP_OFF_WA_CTRL:   next_st.wa_ctrl   = pwdata[7:0];
        `TTCP_OFF_WA_DATA_A: next_st.wa_data_a = pwdata[15:0];
        `TTCP_OFF_WB_CTRL:   next_st.wb_ctrl   = pwdata[7:0];
        `TTCP_OFF_WB_DATA_A: next_st.wb_data_a = pwdata[15:0];
        `TTCP_OFF_IRQ_MASK:  next_st.irq_mask  = pwdata[3:0];
        default:             next_st.b_ctrl    = st.b_ctrl;
      endcase
    end

    // New events win over acceptance or a software clear in the same cycle
    next_st.irq_stat = (st.irq_stat & ~(irq_ack | irq_w1c)) | irq_set;
    next_st.irq      = |(next_st.irq_stat & next_st.irq_mask);

    // Read data and error are prepared in the setup cycle
    if (apb_setup)
    begin
      next_st.prdata  = ttcp_read(paddr, st, wa_if.data_b, wa_if.count,
                                  wb_if.data_b, wb_if.count);
      next_st.pslverr = ~ttcp_mapped(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st          <= '0;
      st.b_ctrl   <= `TTCP_RST_CTRL;
      st.b_cmp    <= `TTCP_RST_BYTE_DATA;
      st.wa_ctrl  <= `TTCP_RST_CTRL;
      st.wb_ctrl  <= `TTCP_RST_CTRL;
      st.irq_stat <= `TTCP_RST_IRQ;
      st.irq_mask <= `TTCP_RST_IRQ;
      st.wa_data_a <= `TTCP_RST_WIDE_DATA;
      st.wb_data_a <= `TTCP_RST_WIDE_DATA;
    end
    else
      st <= next_st;
  end

  // ***********************************************************
  // Outputs
  // ***********************************************************
  // Zero wait states: data was captured in the setup cycle
  assign pready                = 1'b1;
  assign prdata                = st.prdata;
  assign pslverr               = st.pslverr;
  assign byte_timer_toggle_out = st.b_tgl & (byte_mode == 2'b00);
  assign byte_timer_pwm_out    = st.b_pwm;
  assign wide_a_compare_out    = wa_if.cmp_out;
  assign wide_a_pwm_out        = wa_if.pwm_out;
  assign wide_b_toggle_out     = wb_if.cmp_out;
  assign wide_b_pwm_out        = wb_if.pwm_out;
  assign irq                   = st.irq;

endmodule // ttcp_top

// *** testbench/ttcp_top_props.sv ***
// Port checks of the three-timer block
`timescale 1ns/1ps
module ttcp_top_props (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        byte_timer_toggle_out,
  input wire logic        byte_timer_pwm_out,
  input wire logic        wide_a_compare_out,
  input wire logic        wide_a_pwm_out,
  input wire logic        irq
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_tied: assert property (pready) else $error("pready low");
  a_unmapped_err: assert property (psel && !penable && paddr > 8'h34 |=> pslverr)
    else $error("no error");
  a_mapped_ok: assert property (psel && !penable && paddr < 8'h38 && paddr[1:0] == 2'h0
    |=> !pslverr) else $error("false error");
  a_unmapped_zero: assert property (psel && !penable && !pwrite && paddr > 8'h34
    |=> prdata == 32'h0) else $error("read not zero");
  // Read data must not drift while software may still be sampling it
  a_answer_stands: assert property (!(psel && !penable)
    |=> $stable(prdata) && $stable(pslverr)) else $error("answer moved");
  a_byte_off_idle: assert property (psel && penable && pwrite && paddr == 8'h00
    && !pwdata[0] |-> ##[1:3] !byte_timer_toggle_out && !byte_timer_pwm_out)
    else $error("byte pins busy");
  a_wide_off_idle: assert property (psel && penable && pwrite && paddr == 8'h10
    && !pwdata[0] |-> ##[1:3] !wide_a_compare_out && !wide_a_pwm_out)
    else $error("wide pins busy");
  a_mask_quiets: assert property (psel && penable && pwrite && paddr == 8'h34
    && pwdata[3:0] == 4'h0 |=> !irq [*2]) else $error("irq while masked");
endmodule // ttcp_top_props

bind ttcp_top ttcp_top_props i_ttcp_top_props (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .byte_timer_toggle_out, .byte_timer_pwm_out,
  .wide_a_compare_out, .wide_a_pwm_out, .irq);

// *** testbench/ttcp_pins.sv ***
// Pin model: count clocks and capture lines pulsed on command
`timescale 1ns/1ps
module ttcp_pins (
  input wire logic pclk,
  output logic     byte_timer_ext_clk,
  output logic     wide_a_ext_clk,
  output logic     ext_irq_line_one,
  output logic     ext_irq_line_two,
  output logic     ext_irq_line_three
);
  logic [4:0] lvl = 5'h00;
  assign {ext_irq_line_three, ext_irq_line_two, ext_irq_line_one, wide_a_ext_clk,
    byte_timer_ext_clk} = lvl;
  // Four cycles per level keeps edges slower than the synchronisers need
  task automatic pulse(input int idx);
    @(posedge pclk);
    lvl[idx] <= 1'h1;
    repeat (4) @(posedge pclk);
    lvl[idx] <= 1'h0;
    repeat (4) @(posedge pclk);
  endtask
endmodule // ttcp_pins

// *** testbench/ttcp_top_bench.sv ***
// Self-checking bench for the three-timer block
`timescale 1ns/1ps
module ttcp_top_bench;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic [7:0]  paddr = 8'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0]  irq_ack = 4'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, byte_timer_ext_clk, wide_a_ext_clk;
  logic        ext_irq_line_one, ext_irq_line_two, ext_irq_line_three;
  logic        byte_timer_toggle_out, byte_timer_pwm_out, wide_a_compare_out;
  logic        wide_a_pwm_out, wide_b_toggle_out, wide_b_pwm_out;
  int          err_count = 0, n_compared = 0, cyc = 0, n;
  always #50 pclk = ~pclk;
  ttcp_top i_ttcp_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .byte_timer_ext_clk, .wide_a_ext_clk, .ext_irq_line_one,
    .ext_irq_line_two, .ext_irq_line_three, .irq_ack, .byte_timer_toggle_out,
    .byte_timer_pwm_out, .wide_a_compare_out, .wide_a_pwm_out, .wide_b_toggle_out,
    .wide_b_pwm_out, .irq);
  ttcp_pins i_ttcp_pins (.pclk, .byte_timer_ext_clk, .wide_a_ext_clk, .ext_irq_line_one,
    .ext_irq_line_two, .ext_irq_line_three);
  task close_out;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 5000)
    begin
      err_count++;
      close_out();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do @(posedge pclk); while (pready !== 1'h1);
    rd = prdata;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(what, exp, rd);
  endtask
  // Counts rising edges; a bounded window so a dead pin cannot hang the run
  task automatic rises(ref logic s, input int lim, output int cnt);
    logic p;
    p = s;
    cnt = 0;
    for (int i = 0; i < 120 && cnt < lim; i++)
    begin
      @(posedge pclk);
      if (s === 1'h1 && p !== 1'h1)
        cnt++;
      p = s;
    end
  endtask
  task automatic t_regs;
    rdchk("byte ctrl", 8'h00, 32'h0);
    rdchk("unmapped", 8'h38, 32'h0);
    wr(8'h34, 32'hf);
    rdchk("mask", 8'h34, 32'hf);
  endtask
  task automatic t_byte;
    wr(8'h04, 32'h2);
    wr(8'h00, 32'h1);
    rises(byte_timer_toggle_out, 1, n);
    chk("byte toggle", 32'h1, n);
    wr(8'h00, 32'h0);
    rdchk("match flag", 8'h30, 32'h2);
    chk("irq set", 32'h1, {31'h0, irq});
    wr(8'h34, 32'h0);
    irq_ack <= 4'h2;
    @(posedge pclk);
    irq_ack <= 4'h0;
    rdchk("flag served", 8'h30, 32'h0);
    chk("irq low", 32'h0, {31'h0, irq});
    wr(8'h00, 32'h3);
    rises(byte_timer_pwm_out, 1, n);
    chk("byte pwm", 32'h1, n);
    wr(8'h00, 32'h0);
    wr(8'h34, 32'hf);
  endtask
  task automatic t_cap;
    wr(8'h00, 32'h3d);
    wr(8'h10, 32'h3b);
    repeat (3) i_ttcp_pins.pulse(0);
    repeat (2) i_ttcp_pins.pulse(1);
    i_ttcp_pins.pulse(2);
    i_ttcp_pins.pulse(3);
    rdchk("byte capture", 8'h0c, 32'h3);
    rdchk("wide capture", 8'h18, 32'h2);
    wr(8'h00, 32'h0);
    wr(8'h10, 32'h0);
  endtask
  task automatic t_chain;
    wr(8'h24, 32'hffff);
    wr(8'h20, 32'hf9);
    wr(8'h14, 32'h1);
    wr(8'h10, 32'hd9);
    rises(wide_a_compare_out, 2, n);
    chk("a toggles", 32'h2, n);
    wr(8'h10, 32'h0);
    rdchk("chained count", 8'h2c, 32'h3);
    wr(8'h20, 32'h0);
  endtask
  task automatic t_pulse;
    wr(8'h14, 32'h5);
    wr(8'h18, 32'h2);
    wr(8'h10, 32'hc5);
    rises(wide_a_pwm_out, 99, n);
    chk("one-shot pulses", 32'h1, n);
    wr(8'h10, 32'h0);
    wr(8'h10, 32'hc7);
    rises(wide_a_pwm_out, 99, n);
    chk("repeat pulses", 32'h1, {31'h0, n > 12});
    wr(8'h10, 32'h0);
  endtask
  task automatic t_wideb;
    wr(8'h24, 32'h3);
    wr(8'h20, 32'hc1);
    rises(wide_b_toggle_out, 2, n);
    chk("b toggles", 32'h2, n);
    wr(8'h28, 32'h2);
    wr(8'h20, 32'hc7);
    rises(wide_b_pwm_out, 99, n);
    chk("b repeat pulses", 32'h1, {31'h0, n > 12});
    wr(8'h20, 32'h0);
    wr(8'h28, 32'h55);
    // Match source with timer A off: the count stays 0 until captured
    wr(8'h20, 32'h3b);
    i_ttcp_pins.pulse(4);
    rdchk("b capture", 8'h28, 32'h0);
    wr(8'h20, 32'h0);
  endtask
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
    t_regs();
    t_byte();
    t_cap();
    t_chain();
    t_pulse();
    t_wideb();
    close_out();
  end
endmodule // ttcp_top_bench
